// ### design/comparator_control_consts.svh
`ifndef COMPARATOR_CONTROL_CONSTS_SVH
`define COMPARATOR_CONTROL_CONSTS_SVH

// register offsets
`define CMP_ADDR_W 4
`define CMP_OFS_CTRL 4'h0
`define CMP_OFS_PINSEL 4'h1
`define CMP_OFS_INTSTAT 4'h2
`define CMP_OFS_INTCLR 4'h3
`define CMP_OFS_INTEN 4'h4

// control register fields
`define CMP_BIT_ON 6
`define CMP_BIT_INV 5
`define CMP_BIT_RES 4
`define CMP_BIT_HYST 0
`define CMP_CTRL_RST 8'h01

// pin select fields
`define CMP_PIN_POS 0
`define CMP_PIN_NEG 1
`define CMP_PIN_OUT 2
`define CMP_PINSEL_RST 8'h00

// interrupt fields
`define CMP_INT_CHANGE 0
`define CMP_INT_RST 8'h00

// synchroniser depth
`define CMP_SYNC_STAGES 2

`endif

// ### design/comparator_control_pkg.sv
package comparator_control_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [2:0] pinIn;
    logic [2:0] dir;
    logic [2:0] data;
    logic [2:0] pullCfg;
  } shared_pins_t;

endpackage : comparator_control_pkg

// ### design/comparator_sync.sv
`timescale 1ns/1ps
`include "comparator_control_consts.svh"

module comparator_sync #(
  parameter int STAGES = `CMP_SYNC_STAGES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // level in and out
  input wire logic async,
  output logic synced
);

  logic [STAGES-1:0] chain_r;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      chain_r <= '0;
    end else begin
      chain_r <= {chain_r[STAGES-2:0], async};
    end
  end

  assign synced = chain_r[STAGES-1];

endmodule : comparator_sync

// ### design/comparator_control.sv
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "comparator_control_consts.svh"

// Contract
// - comparator powered only while enable bit set
// - clearing enable forces result low
// - invert bit selects raw or inverted decision
// - read-only result bit in control register
// - hysteresis bit read/write, one after reset
// - unused control bits read as zero
// - every result change sets interrupt flag
// - flag and enable request the interrupt
// - result change with flag clear wakes core in low power while the enable bit is set
// - enabled comparator keeps running while asleep
// - owned pins read zero or port data
// - selected input pins drop their pull-high
// - result can drive a shared output pin
module comparator_control (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // register port
  input wire comparator_control_pkg::reg_req_t regReq,
  output logic [7:0] regRdata,
  // analog comparator
  input wire logic rawDecision,
  output logic compPowerOn,
  output logic hystOn,
  // core
  input wire logic lowPowerMode,
  output logic irq,
  output logic wakeReq,
  // shared pins
  input wire comparator_control_pkg::shared_pins_t pins,
  output logic [2:0] portReadVal,
  output logic [2:0] pullHighOn,
  output logic resultPinOut,
  output logic resultPinOeN
);

  ////////////////////////////////////////////////////////////////////////////
  // register state

  logic comparator_on_r;
  logic result_invert_r;
  logic hysteresis_on_r;
  logic [2:0] pinSel_r;
  logic compare_result_r;
  logic intFlag_r;
  logic intEn_r;
  logic wake_r;
  logic [7:0] rdata_r;

  // reset images
  localparam logic [7:0] CTRL_RST = `CMP_CTRL_RST;
  localparam logic [7:0] PINSEL_RST = `CMP_PINSEL_RST;
  localparam logic [7:0] INT_RST = `CMP_INT_RST;

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  wire wrCtrl = regReq.wr && regReq.addr == `CMP_OFS_CTRL;
  wire wrPinSel = regReq.wr && regReq.addr == `CMP_OFS_PINSEL;
  wire wrIntClr = regReq.wr && regReq.addr == `CMP_OFS_INTCLR;
  wire wrIntEn = regReq.wr && regReq.addr == `CMP_OFS_INTEN;

  ////////////////////////////////////////////////////////////////////////////
  // decision path

  logic syncDecision;

  comparator_sync #(
    .STAGES(`CMP_SYNC_STAGES)
  ) u_sync (
    .mclk(mclk),
    .nrst(nrst),
    .async(rawDecision),
    .synced(syncDecision)
  );

  // forced low while off, optionally inverted
  wire compare_result_nxt = comparator_on_r & (syncDecision ^ result_invert_r);
  wire changeEvent = compare_result_nxt != compare_result_r;
  wire clearHit = wrIntClr && regReq.wdata[`CMP_INT_CHANGE];
  wire intFlag_nxt = changeEvent | (intFlag_r & ~clearHit);
  // only a fresh flag while asleep wakes the core
  wire wake_nxt = changeEvent && !intFlag_r && lowPowerMode && comparator_on_r;

  ////////////////////////////////////////////////////////////////////////////
  // read mux

  wire [7:0] ctrlView = {1'b0, comparator_on_r, result_invert_r, compare_result_r,
                         3'b000, hysteresis_on_r};
  wire [7:0] readMux =
    !regReq.rd ? 8'h00 :
    regReq.addr == `CMP_OFS_CTRL ? ctrlView :
    regReq.addr == `CMP_OFS_PINSEL ? {5'b0_0000, pinSel_r} :
    regReq.addr == `CMP_OFS_INTSTAT ? {7'b000_0000, intFlag_r} :
    regReq.addr == `CMP_OFS_INTEN ? {7'b000_0000, intEn_r} : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      comparator_on_r <= CTRL_RST[`CMP_BIT_ON];
      result_invert_r <= CTRL_RST[`CMP_BIT_INV];
      hysteresis_on_r <= CTRL_RST[`CMP_BIT_HYST];
    end else if (wrCtrl) begin
      comparator_on_r <= regReq.wdata[`CMP_BIT_ON];
      result_invert_r <= regReq.wdata[`CMP_BIT_INV];
      hysteresis_on_r <= regReq.wdata[`CMP_BIT_HYST];
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pinSel_r <= PINSEL_RST[2:0];
      intEn_r <= INT_RST[`CMP_INT_CHANGE];
    end else begin
      if (wrPinSel) begin
        pinSel_r <= regReq.wdata[2:0];
      end
      if (wrIntEn) begin
        intEn_r <= regReq.wdata[`CMP_INT_CHANGE];
      end
    end
  end

  // result runs on regardless of low-power mode
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      compare_result_r <= CTRL_RST[`CMP_BIT_RES];
      intFlag_r <= INT_RST[`CMP_INT_CHANGE];
      wake_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      compare_result_r <= compare_result_nxt;
      intFlag_r <= intFlag_nxt;
      wake_r <= wake_nxt;
      rdata_r <= readMux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign regRdata = rdata_r;
  assign compPowerOn = comparator_on_r;
  assign hystOn = hysteresis_on_r;
  assign irq = intFlag_r & intEn_r;
  assign wakeReq = wake_r;

  // pin ownership
  wire [2:0] owned = {comparator_on_r & pinSel_r[`CMP_PIN_OUT],
                      comparator_on_r & pinSel_r[`CMP_PIN_NEG],
                      comparator_on_r & pinSel_r[`CMP_PIN_POS]};
  wire [2:0] inputSel = {1'b0, pinSel_r[`CMP_PIN_NEG], pinSel_r[`CMP_PIN_POS]};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_pin
      assign portReadVal[gi] = owned[gi] ? (pins.dir[gi] ? 1'b0 : pins.data[gi])
                                         : pins.pinIn[gi];
      assign pullHighOn[gi] = pins.pullCfg[gi] & ~inputSel[gi];
    end
  endgenerate

  assign resultPinOut = pinSel_r[`CMP_PIN_OUT] & compare_result_r;
  assign resultPinOeN = ~pinSel_r[`CMP_PIN_OUT];

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  a_power_follows_write: assert property (
    wrCtrl |=> compPowerOn == $past(regReq.wdata[`CMP_BIT_ON]))
    else $error("comparator power does not follow enable write");

  a_off_result_low: assert property (
    !comparator_on_r |=> !compare_result_r)
    else $error("result not forced low while disabled");

  a_invert_path: assert property (
    comparator_on_r |=> compare_result_r == ($past(syncDecision) ^ $past(result_invert_r)))
    else $error("result does not follow decision and polarity");

  a_result_readback: assert property (
    regReq.rd && regReq.addr == `CMP_OFS_CTRL
    |=> regRdata[`CMP_BIT_RES] == $past(compare_result_r)
        && regRdata[`CMP_BIT_ON] == $past(comparator_on_r))
    else $error("control readback wrong");

  a_hyst_write: assert property (
    wrCtrl |=> hystOn == $past(regReq.wdata[`CMP_BIT_HYST]))
    else $error("hysteresis bit does not follow write");

  a_unused_zero: assert property (
    regReq.rd && regReq.addr == `CMP_OFS_CTRL |=> regRdata[7] == 1'b0 && regRdata[3:1] == 3'b000)
    else $error("unused control bits not zero");

  a_change_sets_flag: assert property (
    compare_result_r != $past(compare_result_r) |-> intFlag_r)
    else $error("result change did not set flag");

  a_irq_gate: assert property (
    irq == (intFlag_r && intEn_r))
    else $error("interrupt output not gated by enable");

  a_wake_cause: assert property (
    wakeReq |-> $past(lowPowerMode) && $past(comparator_on_r)
                && compare_result_r != $past(compare_result_r))
    else $error("wake-up without a change in low power");

  a_no_wake_preset: assert property (
    intFlag_r && !clearHit |=> !wakeReq)
    else $error("wake-up despite preset flag");

  a_sync_latency: assert property (
    comparator_on_r && !result_invert_r && rawDecision [*3] |=> compare_result_r)
    else $error("decision not seen within sync latency");

  a_pin_read: assert property (
    owned[0] && pins.dir[0] |-> portReadVal[0] == 1'b0)
    else $error("owned input pin read not zero");

  a_pull_off: assert property (
    pinSel_r[`CMP_PIN_POS] |-> !pullHighOn[0])
    else $error("pull-high left on selected input");

  a_out_pin: assert property (
    !resultPinOeN |-> resultPinOut == compare_result_r)
    else $error("output pin does not carry result");

  a_power_hold: assert property (
    !wrCtrl |=> $stable(compPowerOn))
    else $error("comparator power changed without a write");

  a_disable_falls: assert property (
    comparator_on_r && wrCtrl && !regReq.wdata[`CMP_BIT_ON] |=> ##1 !compare_result_r)
    else $error("result not low after disable");

  a_hyst_hold: assert property (
    !wrCtrl |=> $stable(hystOn))
    else $error("hysteresis changed without a write");

  a_hyst_readback: assert property (
    regReq.rd && regReq.addr == `CMP_OFS_CTRL |=> regRdata[`CMP_BIT_HYST] == $past(hystOn))
    else $error("hysteresis readback wrong");

  a_flag_set_wins: assert property (
    changeEvent && clearHit |=> intFlag_r)
    else $error("clear beat a change in the same cycle");

  a_flag_clear: assert property (
    intFlag_r && clearHit && !changeEvent |=> !intFlag_r)
    else $error("flag not cleared by write");

  a_flag_holds: assert property (
    intFlag_r && !clearHit |=> intFlag_r)
    else $error("flag dropped without a clear");

  a_irq_follows: assert property (
    changeEvent && intEn_r && !wrIntEn |=> irq)
    else $error("enabled change did not raise interrupt");

  a_wake_on_change: assert property (
    changeEvent && !intFlag_r && lowPowerMode && comparator_on_r |=> wakeReq)
    else $error("change in low power did not wake");

  a_wake_pulse: assert property (
    wakeReq |=> !wakeReq)
    else $error("wake-up longer than one cycle");

  a_no_wake_awake: assert property (
    !lowPowerMode |=> !wakeReq)
    else $error("wake-up while not in low power");

  a_pin_data: assert property (
    owned[0] && !pins.dir[0] |-> portReadVal[0] == pins.data[0])
    else $error("owned output pin read not port data");

  a_pull_off_neg: assert property (
    pinSel_r[`CMP_PIN_NEG] |-> !pullHighOn[1])
    else $error("pull-high left on negative input");

  a_out_pin_off: assert property (
    resultPinOeN |-> !resultPinOut)
    else $error("output pin active while not selected");

  a_sync_fall: assert property (
    comparator_on_r && !result_invert_r && !rawDecision [*3] |=> !compare_result_r)
    else $error("low decision not seen within sync latency");

  a_sync_delay: assert property (
    $past(comparator_on_r) && !$past(result_invert_r) |-> compare_result_r == $past(rawDecision, 3))
    else $error("result does not trail decision by sync depth");

endmodule : comparator_control

// ### dv/analog_inputs.sv
`timescale 1ns/1ps
module analog_inputs (
  // comparator state
  input wire logic compPowerOn,
  input wire logic hystOn,
  // input voltages, mV
  input wire logic signed [15:0] posMv,
  input wire logic signed [15:0] negMv,
  // decision
  output logic rawDecision
);
  logic noise = 1'b0;
  logic held = 1'b0;
  wire logic signed [15:0] band = hystOn ? 16'sh000a : 16'sh0000;
  always #40 noise = ~noise;
  // switch point with hysteresis band
  always @* begin
    if (posMv > negMv + band)
      held = 1'b1;
    else if (posMv < negMv - band)
      held = 1'b0;
  end
  // unpowered: no usable decision
  assign rawDecision = compPowerOn ? held : noise;
endmodule : analog_inputs

// ### dv/comparator_control_tb.sv
`timescale 1ns/1ps
`include "comparator_control_consts.svh"
module comparator_control_tb;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  comparator_control_pkg::reg_req_t regReq = '0;
  comparator_control_pkg::shared_pins_t pins = '0;
  logic lowPowerMode = 1'b0;
  logic signed [15:0] posMv = 16'sh0000;
  logic signed [15:0] negMv = 16'sh0064;
  logic [7:0] regRdata, w, rv;
  logic [31:0] rnd;
  logic [2:0] portReadVal, pullHighOn, sel;
  logic rawDecision, compPowerOn, hystOn, irq, wakeReq, resultPinOut, resultPinOeN;
  int n_fail = 0;
  int check_count = 0;
  int seed = 48402;
  int n;

  always #50 mclk = ~mclk;

  comparator_control dut_u (.mclk(mclk), .nrst(nrst), .regReq(regReq), .regRdata(regRdata),
    .rawDecision(rawDecision), .compPowerOn(compPowerOn), .hystOn(hystOn), .lowPowerMode(lowPowerMode),
    .irq(irq), .wakeReq(wakeReq), .pins(pins), .portReadVal(portReadVal), .pullHighOn(pullHighOn),
    .resultPinOut(resultPinOut), .resultPinOeN(resultPinOeN));
  analog_inputs partner_u (.compPowerOn(compPowerOn), .hystOn(hystOn), .posMv(posMv), .negMv(negMv),
    .rawDecision(rawDecision));

  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    regReq.wr <= 1'b1;
    regReq.addr <= a;
    regReq.wdata <= d;
    @(posedge mclk);
    regReq.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    regReq.rd <= 1'b1;
    regReq.addr <= a;
    @(posedge mclk);
    regReq.rd <= 1'b0;
    #1 d = regRdata;
  endtask : rd

  task automatic settle(output int wakes);
    wakes = 0;
    repeat (8) begin
      @(posedge mclk);
      #1 wakes += (wakeReq === 1'b1);
    end
  endtask : settle

  function automatic logic [2:0] port_exp(input logic [2:0] s, input comparator_control_pkg::shared_pins_t p);
    for (int i = 0; i < 3; i++) port_exp[i] = s[i] ? (p.dir[i] ? 1'b0 : p.data[i]) : p.pinIn[i];
  endfunction : port_exp

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out

  ////////////////////////////////////////////////////////////
  initial begin
    #(100 * 6000);
    n_fail++;
    close_out();
  end

  initial begin
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    rd(`CMP_OFS_CTRL, rv);
    chk(rv, 8'h01);
    chk({6'h00, compPowerOn, hystOn}, 8'h01);
    for (int i = 0; i < 8; i++) begin
      rnd = $random(seed);
      w = (i == 0) ? 8'hff : rnd[7:0];
      wr(`CMP_OFS_CTRL, w);
      settle(n);
      rd(`CMP_OFS_CTRL, rv);
      chk(rv, (w & 8'h61) | {3'h0, w[6] & w[5], 4'h0});
      chk({6'h00, compPowerOn, hystOn}, {6'h00, w[6], w[0]});
    end
    $display("test control bits done");
    wr(`CMP_OFS_INTEN, 8'h01);
    for (int k = 0; k < 4; k++) begin
      wr(`CMP_OFS_CTRL, k[1] ? 8'h61 : 8'h41);
      settle(n);
      wr(`CMP_OFS_INTCLR, 8'h01);
      #1 chk({7'h00, irq}, 8'h00);
      posMv <= k[0] ? 16'shfed4 : 16'sh012c;
      settle(n);
      rd(`CMP_OFS_CTRL, rv);
      chk({7'h00, rv[4]}, {7'h00, ~k[0] ^ k[1]});
      rd(`CMP_OFS_INTSTAT, rv);
      chk(rv, 8'h01);
      chk({7'h00, irq}, 8'h01);
    end
    wr(`CMP_OFS_CTRL, 8'h21);
    settle(n);
    rd(`CMP_OFS_CTRL, rv);
    chk(rv, 8'h21);
    $display("test change and disable done");
    wr(`CMP_OFS_CTRL, 8'h41);
    settle(n);
    wr(`CMP_OFS_INTCLR, 8'h01);
    lowPowerMode <= 1'b1;
    posMv <= 16'sh012c;
    settle(n);
    chk(n[7:0], 8'h01);
    posMv <= 16'shfed4;
    settle(n);
    chk(n[7:0], 8'h00);
    lowPowerMode <= 1'b0;
    $display("test wake done");
    for (int j = 0; j < 8; j++) begin
      rnd = $random(seed);
      pins <= rnd[11:0];
      sel = rnd[14:12];
      posMv <= rnd[15] ? 16'sh012c : 16'shfed4;
      wr(`CMP_OFS_PINSEL, {5'h00, sel});
      settle(n);
      chk({5'h00, portReadVal}, {5'h00, port_exp(sel, pins)});
      chk({5'h00, pullHighOn}, {5'h00, pins.pullCfg & {1'b1, ~sel[1:0]}});
      chk({6'h00, resultPinOeN, resultPinOut}, {6'h00, ~sel[2], sel[2] & rnd[15]});
    end
    wr(4'hf, 8'hff);
    rd(4'hf, rv);
    chk(rv, 8'h00);
    $display("test pins and unmapped done");
    close_out();
  end
endmodule : comparator_control_tb
